// ==== sst_pkg.sv ====
// Constants, register map and state record of the shared serial port
// Assumes a 25 MHz system clock and an APB master with 32-bit data
package sst_pkg;
   // ***************************************************
   // Register map (indices; byte address is index * 4)
   // ***************************************************
   localparam logic [7:0] IDX_CTRL = 8'h9D;
   localparam logic [7:0] IDX_ADDR = 8'h9E;
   localparam logic [7:0] IDX_DATA = 8'h9F;
   localparam logic [7:0] IDX_SPI = 8'hA0;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_ADDR = {2'h0, IDX_ADDR, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_SPI = {2'h0, IDX_SPI, 2'h0};

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int B_EN = 7;
   localparam int B_FLAG = 6;
   localparam int B_AA = 3;
   localparam int B_GCEN = 0;
   localparam int B_CLOCK_IDLE_POLARITY = 2;
   localparam int B_CLOCK_SAMPLE_PHASE = 3;
   localparam int B_WRITE_COLLISION_FLAG = 4;
   localparam int B_TRANSFER_COMPLETE_FLAG = 5;
   localparam logic [1:0] FSEL_SPI = 2'h1;
   localparam logic [1:0] FSEL_TWI = 2'h2;
   localparam logic [7:0] SPI_IDLE_BYTE = 8'h00;
   localparam logic [6:0] GC_ADDRESS = 7'h00;
   localparam logic [3:0] BITS = 4'h8;
   localparam logic [3:0] ACK_SLOT = 4'h9;

   // State codes as software sees them
   localparam logic [2:0] C_IDLE = 3'h0;
   localparam logic [2:0] C_ADDR = 3'h1;
   localparam logic [2:0] C_RX = 3'h2;
   localparam logic [2:0] C_TX = 3'h3;
   localparam logic [2:0] C_NACK = 3'h4;
   localparam logic [2:0] C_AAOFF = 3'h5;

   // Pin positions in the synchroniser vectors
   localparam int P_SCK = 0;
   localparam int P_MOSI = 1;
   localparam int P_SS = 2;
   localparam int P_SCL = 3;
   localparam int P_SDA = 4;
   localparam logic [4:0] PINS_IDLE = 5'h1F;

   typedef enum logic [2:0] {
      TW_IDLE, TW_ADDR, TW_RX, TW_TX, TW_NACK, TW_AAOFF
   } sst_tw_state_t;

   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] filt;
      logic en;
      logic flag;
      logic general_call_matched;
      logic aa;
      sst_tw_state_t st;
      logic [7:0] own;
      logic [7:0] dat;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic sda_low;
      logic [1:0] fsel;
      logic clock_idle_polarity;
      logic clock_sample_phase;
      logic write_collision_flag;
      logic transfer_complete_flag;
      logic tx_loaded;
      logic [7:0] tx_sh;
      logic [7:0] rx_sh;
      logic [7:0] rx_buf;
      logic [3:0] scnt;
      logic miso_oe_n;
      logic [31:0] prdata;
   } sst_state_t;
endpackage

// ==== sst_serial_port.sv ====
// Shared serial port: SPI slave and two-wire slave behind an APB slave
// Assumes SCK, SCL come from the external master, sampled by clk
`timescale 1ns/10ps
`default_nettype none
module sst_serial_port (
   // System
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sst_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // SPI pins
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic ss_n_i,
   output logic miso_o,
   output logic miso_oe_n,
   // Two-wire pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   import sst_pkg::*;

   sst_state_t q, n;

   // ***************************************************
   // State code seen by software
   // ***************************************************
   // The enum stays free of codes so the machine can be
   // re-encoded; software only ever sees these fixed codes.
   function automatic logic [2:0] code_of(input sst_tw_state_t s);
      case (s)
         TW_IDLE: code_of = C_IDLE;
         TW_ADDR: code_of = C_ADDR;
         TW_RX: code_of = C_RX;
         TW_TX: code_of = C_TX;
         TW_NACK: code_of = C_NACK;
         TW_AAOFF: code_of = C_AAOFF;
         default: code_of = C_IDLE;
      endcase
   endfunction

   // ***************************************************
   // Next-state logic
   // ***************************************************
   always_comb begin
      // Filtered pin levels and their edges
      logic [4:0] prev;
      logic [4:0] cur;
      logic [4:0] rise;
      logic [4:0] fall;

      // Bus decode and mode
      logic wr;
      logic setup;
      logic spi_on;
      logic twi_on;
      logic ss_act;

      // SPI clock edges
      logic lead;
      logic trail;
      logic sample_e;
      logic shift_e;

      // Two-wire bus events
      logic tw_start;
      logic tw_stop;
      logic addr_hit;
      logic gc_hit;
      logic [7:0] rx_new;
      logic [7:0] sh_new;
      // Every helper gets a value first, so none can hold a latch
      prev = 5'h00;
      cur = 5'h00;
      rise = 5'h00;
      fall = 5'h00;
      wr = 1'b0;
      setup = 1'b0;
      spi_on = 1'b0;
      twi_on = 1'b0;
      ss_act = 1'b0;
      lead = 1'b0;
      trail = 1'b0;
      sample_e = 1'b0;
      shift_e = 1'b0;
      tw_start = 1'b0;
      tw_stop = 1'b0;
      addr_hit = 1'b0;
      gc_hit = 1'b0;
      rx_new = 8'h00;
      sh_new = 8'h00;

      n = q;
      // Three-stage synchroniser; a level counts once stages 2 and 3 agree
      n.s1 = {sda_i, scl_i, ss_n_i, mosi_i, sck_i};
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.filt = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
      prev = q.filt;
      cur = n.filt;
      rise = cur & ~prev;
      fall = ~cur & prev;
      wr = psel & penable & pwrite;
      setup = psel & ~penable;
      spi_on = (q.fsel == FSEL_SPI);
      twi_on = (q.fsel == FSEL_TWI) && q.en;
      ss_act = ~cur[P_SS];
      rx_new = {q.rx_sh[6:0], cur[P_MOSI]};
      sh_new = {q.sh[6:0], 1'b0};

      // ***************************************************
      // Software writes (hardware sets below take priority)
      // ***************************************************
      if (wr) begin
         case (paddr)
            ADDR_CTRL: begin
               n.en = pwdata[B_EN];
               n.aa = pwdata[B_AA];
               if (!pwdata[B_FLAG]) begin
                  n.flag = 1'b0;
               end
            end
            ADDR_ADDR: begin
               n.own = pwdata[7:0];
            end
            ADDR_DATA: begin
               if (spi_on) begin
                  if (q.scnt != 4'h0) begin
                     n.write_collision_flag = 1'b1;
                  end else begin
                     n.tx_sh = pwdata[7:0];
                     n.tx_loaded = 1'b1;
                  end
               end else begin
                  n.dat = pwdata[7:0];
               end
            end
            ADDR_SPI: begin
               n.fsel = pwdata[1:0];
               n.clock_idle_polarity = pwdata[B_CLOCK_IDLE_POLARITY];
               n.clock_sample_phase = pwdata[B_CLOCK_SAMPLE_PHASE];
               // Write one to clear; a same-cycle hardware set wins
               if (pwdata[B_WRITE_COLLISION_FLAG]) begin
                  n.write_collision_flag = 1'b0;
               end
               if (pwdata[B_TRANSFER_COMPLETE_FLAG]) begin
                  n.transfer_complete_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // ***************************************************
      // SPI slave engine
      // ***************************************************
      // Edges come from the filtered clock, so a link half period must
      // last well beyond the three-flop delay; faster masters are lost.
      // Leading edge leaves the idle level chosen by polarity
      lead = q.clock_idle_polarity ? fall[P_SCK] : rise[P_SCK];
      trail = q.clock_idle_polarity ? rise[P_SCK] : fall[P_SCK];
      sample_e = q.clock_sample_phase ? trail : lead;
      shift_e = q.clock_sample_phase ? lead : trail;
      n.miso_oe_n = ~(spi_on & ss_act);
      if (!spi_on || !ss_act) begin
         n.scnt = 4'h0;
      end else begin
         if (sample_e) begin
            n.rx_sh = rx_new;
            if (q.scnt == BITS - 4'h1) begin
               n.scnt = 4'h0;
               // Held byte is kept until software clears completion
               if (!q.transfer_complete_flag) begin
                  n.rx_buf = rx_new;
                  n.transfer_complete_flag = 1'b1;
               end
               n.tx_loaded = 1'b0;
               n.tx_sh = SPI_IDLE_BYTE;
            end else begin
               n.scnt = q.scnt + 4'h1;
            end
         end
         // Phase one: the first leading edge only starts the byte
         if (shift_e && (!q.clock_sample_phase || q.scnt != 4'h0)) begin
            n.tx_sh = {q.tx_sh[6:0], 1'b0};
         end
      end

      // ***************************************************
      // Two-wire slave engine
      // ***************************************************
      // SDA and SCL share one filter delay, so a data change made while
      // SCL is low can never look like a start or stop.
      tw_start = prev[P_SCL] & cur[P_SCL] & fall[P_SDA];
      tw_stop = prev[P_SCL] & cur[P_SCL] & rise[P_SDA];
      // General call only answers a write; a read would collide
      addr_hit = (q.sh[7:1] == q.own[7:1]);
      gc_hit = (q.sh[7:1] == GC_ADDRESS) && q.own[B_GCEN] && !q.sh[0];
      if (!twi_on) begin
         n.st = TW_IDLE;
         n.sda_low = 1'b0;
         n.cnt = 4'h0;
         n.general_call_matched = 1'b0;
      end else if (tw_start) begin
         if (q.st != TW_IDLE) begin
            n.flag = 1'b1;
         end
         n.st = TW_ADDR;
         n.cnt = 4'h0;
         n.sda_low = 1'b0;
         n.general_call_matched = 1'b0;
      end else if (tw_stop) begin
         if (q.st != TW_IDLE) begin
            n.flag = 1'b1;
         end
         n.st = TW_IDLE;
         n.cnt = 4'h0;
         n.sda_low = 1'b0;
         n.general_call_matched = 1'b0;
      end else if (q.st != TW_IDLE) begin
         if (rise[P_SCL]) begin
            if ((q.st == TW_ADDR || q.st == TW_RX) && q.cnt < BITS) begin
               n.sh = {q.sh[6:0], cur[P_SDA]};
            end
            // Master's answer to a sent byte is read on the ninth rise
            if (q.st == TW_TX && q.cnt == BITS) begin
               if (cur[P_SDA]) begin
                  n.st = TW_NACK;
               end else if (!q.aa) begin
                  n.st = TW_AAOFF;
               end
            end
            if (q.cnt < ACK_SLOT) begin
               n.cnt = q.cnt + 4'h1;
            end
         end
         if (fall[P_SCL]) begin
            case (q.st)
               TW_ADDR: begin
                  if (q.cnt == BITS) begin
                     if (addr_hit || gc_hit) begin
                        n.rw = q.sh[0];
                        n.flag = 1'b1;
                        n.general_call_matched = gc_hit;
                        n.sda_low = 1'b1;
                     end else begin
                        n.st = TW_IDLE;
                     end
                  end else if (q.cnt == ACK_SLOT) begin
                     n.sda_low = 1'b0;
                     n.cnt = 4'h0;
                     n.general_call_matched = 1'b0;
                     if (q.rw) begin
                        n.st = TW_TX;
                        n.sh = q.dat;
                        n.sda_low = ~q.dat[7];
                     end else begin
                        n.st = TW_RX;
                     end
                  end
               end
               TW_RX: begin
                  if (q.cnt == BITS) begin
                     n.dat = q.sh;
                     n.flag = 1'b1;
                     n.sda_low = q.aa;
                  end else if (q.cnt == ACK_SLOT) begin
                     n.sda_low = 1'b0;
                     n.cnt = 4'h0;
                     // A refused byte ends the slave's part of the transfer
                     if (!q.sda_low) begin
                        n.st = TW_IDLE;
                     end
                  end
               end
               TW_TX: begin
                  if (q.cnt >= 4'h1 && q.cnt < BITS) begin
                     n.sh = sh_new;
                     n.sda_low = ~sh_new[7];
                  end else if (q.cnt == BITS) begin
                     n.sda_low = 1'b0;
                     n.flag = 1'b1;
                  end else if (q.cnt == ACK_SLOT) begin
                     n.cnt = 4'h0;
                     n.sh = q.dat;
                     n.sda_low = ~q.dat[7];
                  end
               end
               default: begin
                  // Waiting states keep the line released
                  n.sda_low = 1'b0;
               end
            endcase
         end
      end

      // ***************************************************
      // Read data captured in the setup phase
      // ***************************************************
      // Capturing one cycle early lets pready stay tied high; the
      // value read is the state as the setup cycle found it.
      if (setup) begin
         case (paddr)
            ADDR_CTRL: begin
               n.prdata = {24'h0, q.en, q.flag, 1'b0, q.general_call_matched, q.aa,
                           code_of(q.st)};
            end
            ADDR_ADDR: begin
               n.prdata = {24'h0, q.own};
            end
            ADDR_DATA: begin
               n.prdata = {24'h0, spi_on ? q.rx_buf : q.dat};
            end
            ADDR_SPI: begin
               n.prdata = {25'h0, q.tx_loaded, q.transfer_complete_flag, q.write_collision_flag, q.clock_sample_phase,
                           q.clock_idle_polarity, q.fsel};
            end
            default: begin
               n.prdata = 32'h0;
            end
         endcase
      end
   end

   // ***************************************************
   // State register
   // ***************************************************
   // Synchronisers reset to the idle-high pin levels, so no false edge
   // is seen on the link once reset is released.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.s1 <= PINS_IDLE;
         q.s2 <= PINS_IDLE;
         q.s3 <= PINS_IDLE;
         q.filt <= PINS_IDLE;
         q.st <= TW_IDLE;
         q.miso_oe_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign prdata = q.prdata;
   // Zero wait states: every register answers in the first access cycle
   assign pready = 1'b1;
   // Unmapped offsets answer with an error; writes there are dropped
   assign pslverr = psel & penable & (paddr != ADDR_CTRL) &
                    (paddr != ADDR_ADDR) & (paddr != ADDR_DATA) &
                    (paddr != ADDR_SPI);
   // MSB first; the idle byte after a transfer shifts out zeros
   assign miso_o = q.tx_sh[7];
   assign miso_oe_n = q.miso_oe_n;
   // Open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_n = ~q.sda_low;
endmodule
`default_nettype wire

// ==== sst_serial_port_assertions.sv ====
// Pin and bus checks of the shared serial port
// Bound to sst_serial_port; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module sst_serial_port_assertions (
   // System
   input wire logic clk,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic [sst_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic ss_n_i,
   input wire logic miso_oe_n,
   input wire logic sda_o,
   input wire logic sda_oe_n
);
   import sst_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire mapped = paddr == ADDR_CTRL || paddr == ADDR_ADDR ||
      paddr == ADDR_DATA || paddr == ADDR_SPI;
   // ****************
   // Properties
   // ****************
   // A link bit lasts 16 clocks; 6 leaves room for synchroniser skew
   sequence s_held; !sda_oe_n [*6]; endsequence
   sequence s_free; sda_oe_n [*6]; endsequence
   sequence s_unsel; ss_n_i [*6]; endsequence
   property p_ready; pready; endproperty
   property p_err; pslverr == (psel && penable && !mapped); endproperty
   property p_high; prdata[31:8] == 24'h0; endproperty
   property p_open; sda_o == 1'b0; endproperty
   property p_ack; $fell(sda_oe_n) |-> s_held; endproperty
   property p_rel; $rose(sda_oe_n) |-> s_free; endproperty
   property p_miso; s_unsel |=> miso_oe_n; endproperty
   property p_boot; $rose(rst_n) |-> sda_oe_n && miso_oe_n; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   a_err: assert property (p_err) else $error("pslverr wrong");
   a_high: assert property (p_high) else $error("prdata upper bits set");
   a_open: assert property (p_open) else $error("sda driven high");
   a_ack: assert property (p_ack) else $error("sda low too short");
   a_rel: assert property (p_rel) else $error("sda release short");
   a_miso: assert property (p_miso) else $error("miso driven unselected");
   a_boot: assert property (p_boot) else $error("pins driven at boot");
endmodule
bind sst_serial_port sst_serial_port_assertions u_sst_serial_port_assertions (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ss_n_i(ss_n_i), .miso_oe_n(miso_oe_n), .sda_o(sda_o),
   .sda_oe_n(sda_oe_n));
`default_nettype wire

// ==== sst_link_master.sv ====
// Behavioural far side: two-wire master and SPI master
// SDA pull-up and wire level are formed in the bench
`timescale 1ns/10ps
`default_nettype none
module sst_link_master (
   // Two-wire
   output logic scl,
   output logic sda_pull,
   input wire logic sda,
   // SPI
   output logic sck,
   output logic mosi,
   output logic ss_n,
   input wire logic miso_o,
   input wire logic miso_oe_n
);
   // Quarter link period; pins pass three flops, so edges stay slow
   localparam time Q = 160;
   logic clock_idle_polarity = 1'b0;
   logic clock_sample_phase = 1'b0;
   logic [7:0] rx = 8'h00;
   // Released MISO shows the inverse of its last bit
   wire miso = miso_oe_n ? ~rx[0] : miso_o;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
      sck = 1'b0;
      mosi = 1'b0;
      ss_n = 1'b1;
   end
   // ****************
   // Two-wire
   // ****************
   task automatic tw_start();
      sda_pull = 1'b0;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b1;
      #Q scl = 1'b0;
   endtask
   task automatic tw_stop();
      #Q sda_pull = 1'b1;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b0;
      #Q;
   endtask
   task automatic tw_bit(input logic b, output logic s);
      #Q sda_pull = ~b;
      #Q scl = 1'b1;
      #Q s = sda;
      #Q scl = 1'b0;
   endtask
   // Send 8'hFF to read; m is the master's own ninth bit
   task automatic tw_byte(input logic [7:0] d, input logic m,
      output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--)
         tw_bit(d[i], r[i]);
      tw_bit(m, a);
   endtask
   // ****************
   // SPI
   // ****************
   task automatic spi(input logic [7:0] t, output logic [7:0] r);
      sck = clock_idle_polarity;
      #(2*Q) ss_n = 1'b0;
      #(2*Q);
      for (int i = 7; i >= 0; i--) begin
         if (!clock_sample_phase)
            mosi = t[i];
         #(2*Q) sck = ~clock_idle_polarity;
         if (clock_sample_phase)
            mosi = t[i];
         else
            rx = {rx[6:0], miso};
         #(2*Q) sck = clock_idle_polarity;
         if (clock_sample_phase)
            rx = {rx[6:0], miso};
      end
      #(2*Q) ss_n = 1'b1;
      mosi = ~mosi;
      r = rx;
   endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench of the shared serial port
// Bench is APB master; sst_link_master drives the link pins
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import sst_pkg::*;
   typedef struct packed {
      logic w;
      logic [ADDR_W-1:0] a;
      logic [7:0] d;
      logic e;
   } sst_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, miso_o, miso_oe_n, sda_o, sda_oe_n;
   logic scl, sda_pull, sck, mosi, ss_n, k, e;
   logic [7:0] r;
   logic [31:0] q;
   int n_fail = 0;
   int num_checks = 0;
   wire sda = ~sda_pull & (sda_oe_n | sda_o);
   sst_row_t rows [12] = '{
      '{1'b1, ADDR_SPI, 8'h02, 1'b0},
      '{1'b0, ADDR_CTRL, 8'h00, 1'b0},
      '{1'b0, ADDR_ADDR, 8'h00, 1'b0},
      '{1'b0, ADDR_DATA, 8'h00, 1'b0},
      '{1'b1, ADDR_ADDR, 8'hA1, 1'b0},
      '{1'b0, ADDR_ADDR, 8'hA1, 1'b0},
      '{1'b1, ADDR_CTRL, 8'h88, 1'b0},
      '{1'b0, ADDR_CTRL, 8'h88, 1'b0},
      '{1'b1, ADDR_DATA, 8'h5A, 1'b0},
      '{1'b0, ADDR_DATA, 8'h5A, 1'b0},
      '{1'b0, 12'h000, 8'h00, 1'b1},
      '{1'b1, 12'h004, 8'h00, 1'b1}};
   sst_serial_port u_sst_serial_port (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sck_i(sck), .mosi_i(mosi),
      .ss_n_i(ss_n), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
   sst_link_master u_m (
      .scl(scl), .sda_pull(sda_pull), .sda(sda), .sck(sck), .mosi(mosi),
      .ss_n(ss_n), .miso_o(miso_o), .miso_oe_n(miso_oe_n));
   initial begin
      forever #20 clk = ~clk;
   end
   // ****************
   // Tasks
   // ****************
   task automatic chk(input string n, input logic [31:0] x,
      input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
      input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   // Waits first so link events seen through the synchroniser land
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] x);
      repeat (8) @(posedge clk);
      apb(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), {24'h0, x}, q);
   endtask
   task automatic ack(input logic x);
      chk("ack bit", {31'h0, x}, {31'h0, k});
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Whole run needs about 0.13 ms
   initial begin
      #1500000;
      n_fail++;
      test_done();
   end
   // ****************
   // Tests
   // ****************
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w)
            chk("row data", {24'h0, rows[i].d}, q);
         chk("row error", {31'h0, rows[i].e}, {31'h0, e});
      end
      $display("register rows done");
      wr(ADDR_ADDR, 8'hA0);
      u_m.tw_start();
      u_m.tw_byte(8'hA2, 1'b1, r, k);
      ack(1'b1);
      u_m.tw_stop();
      u_m.tw_start();
      u_m.tw_byte(8'hA0, 1'b1, r, k);
      ack(1'b0);
      rd(ADDR_CTRL, 8'hCA);
      wr(ADDR_CTRL, 8'h88);
      u_m.tw_byte(8'h3C, 1'b1, r, k);
      ack(1'b0);
      rd(ADDR_DATA, 8'h3C);
      rd(ADDR_CTRL, 8'hCA);
      wr(ADDR_CTRL, 8'h88);
      u_m.tw_stop();
      rd(ADDR_CTRL, 8'hC8);
      wr(ADDR_DATA, 8'h96);
      u_m.tw_start();
      u_m.tw_byte(8'hA1, 1'b1, r, k);
      rd(ADDR_CTRL, 8'hCB);
      u_m.tw_byte(8'hFF, 1'b1, r, k);
      chk("byte to master", 32'h96, {24'h0, r});
      rd(ADDR_CTRL, 8'hCC);
      u_m.tw_stop();
      u_m.tw_start();
      u_m.tw_byte(8'hA1, 1'b1, r, k);
      wr(ADDR_CTRL, 8'h80);
      u_m.tw_byte(8'hFF, 1'b0, r, k);
      rd(ADDR_CTRL, 8'hC5);
      u_m.tw_stop();
      for (int g = 0; g < 2; g++) begin
         wr(ADDR_ADDR, {7'h50, g[0]});
         wr(ADDR_CTRL, 8'h88);
         u_m.tw_start();
         u_m.tw_byte(8'h00, 1'b1, r, k);
         ack(~g[0]);
         u_m.tw_stop();
      end
      wr(ADDR_CTRL, 8'h80);
      u_m.tw_start();
      u_m.tw_byte(8'hA0, 1'b1, r, k);
      u_m.tw_byte(8'h3C, 1'b1, r, k);
      ack(1'b1);
      u_m.tw_stop();
      $display("two-wire tests done");
      for (int m = 0; m < 4; m++) begin
         u_m.clock_idle_polarity = m[0];
         u_m.clock_sample_phase = m[1];
         wr(ADDR_SPI, {4'h2, m[1:0], 2'h1});
         wr(ADDR_DATA, 8'h3C ^ 8'(m));
         u_m.spi(8'hA5 ^ 8'(m), r);
         chk("spi out", {24'h0, 8'h3C ^ 8'(m)}, {24'h0, r});
         rd(ADDR_DATA, 8'hA5 ^ 8'(m));
      end
      u_m.spi(8'h66, r);
      chk("idle byte", 32'h0, {24'h0, r});
      rd(ADDR_DATA, 8'hA6);
      u_m.clock_idle_polarity = 1'b0;
      u_m.clock_sample_phase = 1'b0;
      wr(ADDR_SPI, 8'h31);
      wr(ADDR_DATA, 8'hC3);
      fork
         u_m.spi(8'h00, r);
         begin
            repeat (60) @(posedge clk);
            wr(ADDR_DATA, 8'h77);
         end
      join
      chk("shifted byte", 32'hC3, {24'h0, r});
      repeat (100) @(posedge clk);
      rd(ADDR_SPI, 8'h31);
      wr(ADDR_SPI, 8'h31);
      rd(ADDR_SPI, 8'h01);
      $display("spi tests done");
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADDR_ADDR, 8'h00);
      $display("second reset done");
      test_done();
   end
endmodule
`default_nettype wire
